// file: cwr_consts.svh
// constants for the configuration word and reset feature block
`ifndef CWR_CONSTS_SVH
`define CWR_CONSTS_SVH

`define CWR_CFG_W 16
`define CWR_CFG_ERASED 16'hffff
`define CWR_CFG_IMPL_MASK 16'h805f
`define CWR_PM_HI_BIT 15
`define CWR_PM_MID_BIT 6
`define CWR_PM_LO_BIT 4
`define CWR_WDTPS_HI_BIT 3
`define CWR_WDTPS_LO_BIT 2
`define CWR_FOSC_HI_BIT 1
`define CWR_FOSC_LO_BIT 0

`define CWR_WDT_OFF 2'h0
`define CWR_WDT_PS_01 64
`define CWR_WDT_PS_10 256
`define CWR_WDT_PS_11 1
`define CWR_WDT_BASE 256
`define CWR_WDT_OVF_TICKS 65536
`define CWR_WDT_W 24

`define CWR_POWER_UP_DELAY_TIMER_TIME_MS 96
`define CWR_CORE_CLK_HZ 10000000
`define CWR_MS_PER_S 1000
`define CWR_OST_CYCLES 1024
`define CWR_TMR_W 20

`define CWR_ADDR_W 4
`define CWR_ADDR_CONFIG 4'h0
`define CWR_ADDR_STATUS 4'h4
`define CWR_ADDR_CONTROL 4'h8

`define CWR_ST_IN_RESET 0
`define CWR_ST_HALTED 1
`define CWR_ST_CAUSE_POR 2
`define CWR_ST_CAUSE_EXT 3
`define CWR_ST_CAUSE_WDT 4
`define CWR_ST_WDT_OVF 5

`define CWR_CTL_SLEEP 0
`define CWR_CTL_WDT_CLR 1
`define CWR_CTL_OVF_CLR 2

`define CWR_RESP_OKAY 2'h0
`define CWR_RESP_SLVERR 2'h2

`endif

// file: cwr_pkg.sv
// types for the configuration word and reset feature block
package cwr_pkg;
	typedef enum logic [6:0] {
		cwr_st_load = 7'h01,
		cwr_st_power_up_delay_timer = 7'h02,
		cwr_st_ost = 7'h04,
		cwr_st_xrst = 7'h08,
		cwr_st_run = 7'h10,
		cwr_st_halt = 7'h20,
		cwr_st_wake = 7'h40
	} cwr_state_t;

	typedef enum logic [1:0] {
		cwr_osc_lf = 2'h0,
		cwr_osc_rc = 2'h1,
		cwr_osc_xt = 2'h2,
		cwr_osc_ec = 2'h3
	} cwr_osc_t;

	typedef enum logic [2:0] {
		cwr_cause_por = 3'h1,
		cwr_cause_ext = 3'h2,
		cwr_cause_wdt = 3'h4
	} cwr_cause_t;
endpackage

// file: cwr_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cwr_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic pin_in,
	output logic level,
	output logic changed
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;
	logic next_changed;

	// s1 feeds s2 only; the filter looks at s2 and s3
	always_comb begin
		next_level = level;
		next_changed = 1'b0;
		if (s2 == s3 && s3 != level) begin
			next_level = s3;
			next_changed = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			level <= RST_VAL;
			changed <= 1'b0;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
			changed <= next_changed;
		end
	end
endmodule

// file: cwr_top.sv
// configuration word decode, reset sequencing, watchdog and halt control
//
// Overview of operation
// [R01] watchdog can be turned off only by the configuration word, never by software
// [R02] watchdog counts ticks of its own RC oscillator, not the system clock
// [R03] oscillator settle timer holds core reset until the crystal is stable
// [R04] power-up delay of 96 ms holds reset, started by power-on only
// [R05] halt ends on external reset, watchdog reset or an interrupt
// [R06] oscillator type and options come from the nonvolatile configuration word
// [R07] decode mode, watchdog and oscillator fields; unimplemented bits read as one
`include "cwr_consts.svh"
`timescale 1ns/1ps
module cwr_top
	import cwr_pkg::*;
#(
	parameter int unsigned POWER_UP_DELAY_TIMER_CYC = `CWR_POWER_UP_DELAY_TIMER_TIME_MS * (`CWR_CORE_CLK_HZ / `CWR_MS_PER_S),
	parameter int unsigned OST_CYC = `CWR_OST_CYCLES,
	parameter int unsigned WDT_BASE = `CWR_WDT_BASE
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [`CWR_CFG_W-1:0] cfg_word_in,
	input wire logic ext_reset_b,
	input wire logic wdt_rc_clk,
	input wire logic irq_wake,
	output logic core_reset_b,
	output logic core_halt,
	output logic [2:0] proc_mode,
	output logic [1:0] osc_type,
	input wire logic [`CWR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`CWR_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam logic [`CWR_TMR_W-1:0] POWER_UP_DELAY_TIMER_LAST = `CWR_TMR_W'(POWER_UP_DELAY_TIMER_CYC - 1);
	localparam logic [`CWR_TMR_W-1:0] OST_LAST = `CWR_TMR_W'(OST_CYC - 1);

	logic ext_level;
	logic rc_level;
	logic rc_changed;
	logic rc_tick;

	cwr_sync3 #(.RST_VAL(1'b1)) u_ext_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_in(ext_reset_b),
		.level(ext_level),
		.changed()
	);

	cwr_sync3 #(.RST_VAL(1'b0)) u_rc_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_in(wdt_rc_clk),
		.level(rc_level),
		.changed(rc_changed)
	);

	// one tick per rising edge of the watchdog RC oscillator
	assign rc_tick = rc_changed && rc_level; // [R02]

	logic [`CWR_CFG_W-1:0] cfg_word;
	cwr_state_t state;
	cwr_state_t next_state;
	logic [`CWR_TMR_W-1:0] tmr;
	logic [`CWR_TMR_W-1:0] next_tmr;
	logic [2:0] cause;
	logic [2:0] next_cause;
	logic [`CWR_CFG_W-1:0] next_cfg_word;
	logic next_core_reset_b;
	logic next_core_halt;
	logic core_in_reset;
	logic needs_settle;
	logic [1:0] wdt_sel;
	logic wdt_timeout;
	logic wr_sleep;
	logic wr_wdt_clr;
	logic wr_ovf_clr;

	// fields are read from the captured word only
	assign proc_mode = {cfg_word[`CWR_PM_HI_BIT], cfg_word[`CWR_PM_MID_BIT], cfg_word[`CWR_PM_LO_BIT]}; // [R07]
	assign osc_type = {cfg_word[`CWR_FOSC_HI_BIT], cfg_word[`CWR_FOSC_LO_BIT]}; // [R06]
	assign wdt_sel = {cfg_word[`CWR_WDTPS_HI_BIT], cfg_word[`CWR_WDTPS_LO_BIT]}; // [R07]
	// rc and external clock need no settling; crystals do
	assign needs_settle = (osc_type == cwr_osc_xt) || (osc_type == cwr_osc_lf); // [R03]
	assign core_in_reset = (state == cwr_st_load) || (state == cwr_st_power_up_delay_timer) ||
		(state == cwr_st_ost) || (state == cwr_st_xrst);

	always_comb begin
		next_state = state;
		next_tmr = tmr + `CWR_TMR_W'(1);
		next_cause = cause;
		next_cfg_word = cfg_word;
		case (state)
			cwr_st_load: begin
				// word latched once, after power-on release
				next_cfg_word = cfg_word_in | ~`CWR_CFG_IMPL_MASK; // [R06] [R07]
				next_state = cwr_st_power_up_delay_timer; // [R04]
				next_cause = cwr_cause_por;
				next_tmr = '0;
			end
			cwr_st_power_up_delay_timer: begin
				if (tmr == POWER_UP_DELAY_TIMER_LAST) begin // [R04]
					next_tmr = '0;
					next_state = needs_settle ? cwr_st_ost : cwr_st_run;
				end
			end
			cwr_st_ost: begin
				if (tmr == OST_LAST) begin // [R03]
					next_tmr = '0;
					next_state = cwr_st_run;
				end
			end
			cwr_st_xrst: begin
				next_tmr = '0;
				if (ext_level) begin
					next_state = needs_settle ? cwr_st_ost : cwr_st_run; // [R03]
				end
			end
			cwr_st_run: begin
				next_tmr = '0;
				if (wr_sleep) begin
					next_state = cwr_st_halt;
				end
			end
			cwr_st_halt: begin
				next_tmr = '0;
				if (irq_wake) begin // [R05]
					next_state = needs_settle ? cwr_st_wake : cwr_st_run;
				end
			end
			cwr_st_wake: begin
				if (tmr == OST_LAST) begin // [R03]
					next_tmr = '0;
					next_state = cwr_st_run;
				end
			end
			default: begin
				next_state = cwr_st_load;
				next_tmr = '0;
			end
		endcase
		// external reset is ignored during the power-up delay so it cannot shorten it
		if (!ext_level && (state == cwr_st_ost || state == cwr_st_run ||
			state == cwr_st_halt || state == cwr_st_wake)) begin
			next_state = cwr_st_xrst; // [R04] [R05]
			next_cause = cwr_cause_ext;
			next_tmr = '0;
		end else if (wdt_timeout) begin
			next_state = needs_settle ? cwr_st_ost : cwr_st_run; // [R05]
			next_cause = cwr_cause_wdt;
			next_tmr = '0;
		end
		next_core_reset_b = (next_state == cwr_st_run) || (next_state == cwr_st_halt) ||
			(next_state == cwr_st_wake); // [R03] [R04]
		next_core_halt = (next_state == cwr_st_halt) || (next_state == cwr_st_wake);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= cwr_st_load;
			tmr <= '0;
			cause <= cwr_cause_por;
			cfg_word <= `CWR_CFG_ERASED;
			core_reset_b <= 1'b0;
			core_halt <= 1'b0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			cause <= next_cause;
			cfg_word <= next_cfg_word;
			core_reset_b <= next_core_reset_b;
			core_halt <= next_core_halt;
		end
	end

	logic [`CWR_WDT_W-1:0] wdt_cnt;
	logic [`CWR_WDT_W-1:0] next_wdt_cnt;
	logic [`CWR_WDT_W-1:0] wdt_last;
	logic wdt_ovf;
	logic next_wdt_ovf;
	logic wdt_wrap;

	always_comb begin
		case (wdt_sel)
			`CWR_WDT_OFF: wdt_last = `CWR_WDT_W'(`CWR_WDT_OVF_TICKS - 1);
			2'h1: wdt_last = `CWR_WDT_W'(WDT_BASE * `CWR_WDT_PS_01 - 1);
			2'h2: wdt_last = `CWR_WDT_W'(WDT_BASE * `CWR_WDT_PS_10 - 1);
			default: wdt_last = `CWR_WDT_W'(WDT_BASE * `CWR_WDT_PS_11 - 1);
		endcase
		wdt_wrap = rc_tick && !core_in_reset && (wdt_cnt == wdt_last);
		// only the captured field can disable it; no software bit does
		wdt_timeout = wdt_wrap && (wdt_sel != `CWR_WDT_OFF); // [R01]
		next_wdt_cnt = wdt_cnt;
		if (core_in_reset || wr_wdt_clr || wdt_wrap) begin
			next_wdt_cnt = '0;
		end else if (rc_tick) begin
			next_wdt_cnt = wdt_cnt + `CWR_WDT_W'(1); // [R02]
		end
		// a wrap in the clearing cycle still sets the flag
		next_wdt_ovf = (wdt_wrap && (wdt_sel == `CWR_WDT_OFF)) || (wdt_ovf && !wr_ovf_clr);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wdt_cnt <= '0;
			wdt_ovf <= 1'b0;
		end else begin
			wdt_cnt <= next_wdt_cnt;
			wdt_ovf <= next_wdt_ovf;
		end
	end

	logic aw_held;
	logic w_held;
	logic [`CWR_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;
	logic next_aw_held;
	logic next_w_held;
	logic [`CWR_ADDR_W-1:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic next_w_lane0;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic do_write;
	logic [31:0] status_word;

	assign status_word = {26'h0, wdt_ovf, cause, core_halt, !core_reset_b};

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_lane0 = s_axi_wstrb[0];
		end
		do_write = aw_held && w_held && !s_axi_bvalid;
		wr_sleep = 1'b0;
		wr_wdt_clr = 1'b0;
		wr_ovf_clr = 1'b0;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `CWR_RESP_OKAY;
			if (aw_addr == `CWR_ADDR_CONTROL) begin
				// sleep is refused while the core is held in reset
				wr_sleep = w_lane0 && w_data[`CWR_CTL_SLEEP] && !core_in_reset;
				wr_wdt_clr = w_lane0 && w_data[`CWR_CTL_WDT_CLR];
				wr_ovf_clr = w_lane0 && w_data[`CWR_CTL_OVF_CLR];
			end else if (aw_addr != `CWR_ADDR_CONFIG && aw_addr != `CWR_ADDR_STATUS) begin
				next_bresp = `CWR_RESP_SLVERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `CWR_RESP_OKAY;
			case (s_axi_araddr)
				`CWR_ADDR_CONFIG: next_rdata = {16'h0, cfg_word}; // [R07]
				`CWR_ADDR_STATUS: next_rdata = status_word;
				`CWR_ADDR_CONTROL: next_rdata = 32'h0;
				default: begin
					next_rdata = 32'h0;
					next_rresp = `CWR_RESP_SLVERR;
				end
			endcase
		end
		next_awready = !next_aw_held;
		next_wready = !next_w_held;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CWR_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `CWR_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule

// file: cwr_top_monitor.sv
// checker for the configuration word and reset feature block
`timescale 1ns/1ps
module cwr_top_monitor #(
	parameter int unsigned POWER_UP_DELAY_TIMER_CYC = 50,
	parameter int unsigned OST_CYC = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [15:0] cfg_word_in,
	input wire logic ext_reset_b,
	input wire logic wdt_rc_clk,
	input wire logic irq_wake,
	input wire logic core_reset_b,
	input wire logic core_halt,
	input wire logic [2:0] proc_mode,
	input wire logic [1:0] osc_type
);
	logic [19:0] cnt;
	logic [19:0] next_cnt;
	logic settled;
	// saturates so a long run never wraps back into the power-up window
	always_comb begin
		next_cnt = cnt;
		if (cnt != 20'hfffff) begin
			next_cnt = cnt + 20'h1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cnt <= 20'h0;
		end else begin
			cnt <= next_cnt;
		end
	end
	assign settled = cnt > POWER_UP_DELAY_TIMER_CYC + OST_CYC + 8;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_halt_irq;
		core_halt && irq_wake && core_reset_b;
	endsequence
	// sync delay is under eight cycles, so eight quiet cycles rule out a tick in flight
	sequence s_rc_quiet;
		(ext_reset_b && $stable(wdt_rc_clk))[*8];
	endsequence
	AST_POWER_UP_DELAY_TIMER_HOLD: assert property (cnt < POWER_UP_DELAY_TIMER_CYC |-> !core_reset_b)
		else $error("core left reset inside power-up delay");
	AST_CFG_STATIC: assert property (cnt > 3 |-> $stable({proc_mode, osc_type}))
		else $error("decoded options changed after load");
	AST_DECODE: assert property (cnt > 3 |-> proc_mode == {cfg_word_in[15], cfg_word_in[6], cfg_word_in[4]}
		&& osc_type == cfg_word_in[1:0]) else $error("option decode wrong");
	AST_OST_HOLD: assert property ($rose(ext_reset_b) && !core_reset_b && !osc_type[0] && settled
		|-> !core_reset_b[*8]) else $error("crystal released before settle time");
	AST_NO_POWER_UP_DELAY_TIMER_AGAIN: assert property ($rose(ext_reset_b) && settled |-> ##[1:20] core_reset_b)
		else $error("external reset took too long to release");
	AST_IRQ_WAKE: assert property (s_halt_irq |-> ##[1:14] !core_halt)
		else $error("interrupt did not end halt");
	AST_EXT_WAKE: assert property (core_halt && !ext_reset_b |-> ##[1:6] !core_halt)
		else $error("external reset did not end halt");
	AST_WDT_OWN_CLK: assert property (s_rc_quiet |-> !$fell(core_reset_b))
		else $error("reset without watchdog clock activity");
endmodule
bind cwr_top cwr_top_monitor #(.POWER_UP_DELAY_TIMER_CYC(POWER_UP_DELAY_TIMER_CYC), .OST_CYC(OST_CYC)) u_mon (.core_clk, .rst_b,
	.cfg_word_in, .ext_reset_b, .wdt_rc_clk, .irq_wake, .core_reset_b, .core_halt, .proc_mode, .osc_type);

// file: cwr_top_tb_top.sv
// self-checking bench for the configuration word and reset feature block
`timescale 1ns/1ps
module cwr_top_tb_top;
	localparam int PW = 50;
	localparam int OS = 8;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic ext_reset_b = 1'b1;
	logic wdt_rc_clk = 1'b0;
	logic irq_wake = 1'b0;
	logic [15:0] cfg_word_in = 16'hffff;
	logic [3:0] s_axi_awaddr = 4'h0;
	logic [3:0] s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic core_reset_b, core_halt, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, prv;
	logic [2:0] proc_mode;
	logic [1:0] osc_type, s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int n_mismatch = 0;
	int checks_done = 0;
	int n_fall = 0;
	int n;
	always #50 core_clk = ~core_clk;
	cwr_top #(.POWER_UP_DELAY_TIMER_CYC(PW), .OST_CYC(OS), .WDT_BASE(2)) dut (.core_clk, .rst_b, .cfg_word_in, .ext_reset_b,
		.wdt_rc_clk, .irq_wake, .core_reset_b, .core_halt, .proc_mode, .osc_type, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	// counts core reset drops seen at the pin
	always @(posedge core_clk) begin
		if (prv === 1'b1 && core_reset_b === 1'b0) n_fall++;
		prv <= core_reset_b;
	end
	task automatic close_out;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge core_clk);
			if (s_axi_awready && s_axi_awvalid) begin
				s_axi_awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				s_axi_wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, 2'h0);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
	endtask
	// h picks core_halt, else core_reset_b; n counts edges waited
	task automatic wt(input bit h, input logic v);
		n = 0;
		while ((h ? core_halt : core_reset_b) !== v && n < 300) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	task automatic ticks(input int k);
		repeat (k) begin
			wdt_rc_clk <= 1'b1;
			cyc(4);
			wdt_rc_clk <= 1'b0;
			cyc(4);
		end
	endtask
	task automatic boot(input logic [15:0] c, input logic [4:0] m);
		rst_b <= 1'b0;
		cfg_word_in <= c;
		cyc(20);
		rst_b <= 1'b1;
		cyc(3);
		chk({proc_mode, osc_type}, m);
		wt(0, 1'b1);
	endtask
	initial begin
		boot(16'h004e, 5'b01010);
		chk(n + 3 >= PW + OS && n + 3 <= PW + OS + 5, 1);
		rd(4'h0, 32'h7fee, 2'h0);
		rd(4'h4, 32'h4, 2'h0);
		rd(4'hc, 32'h0, 2'h2);
		wr(4'h0, 32'h0);
		rd(4'h0, 32'h7fee, 2'h0);
		wr(4'h8, 32'h1);
		cyc(1);
		chk(core_halt, 1);
		irq_wake <= 1'b1;
		wt(1, 1'b0);
		irq_wake <= 1'b0;
		chk(n >= OS && n <= OS + 6, 1);
		wr(4'h8, 32'h1);
		cyc(1);
		ext_reset_b <= 1'b0;
		cyc(10);
		chk({core_halt, core_reset_b}, 2'b00);
		ext_reset_b <= 1'b1;
		wt(0, 1'b1);
		chk(n >= OS && n <= OS + 8, 1);
		rd(4'h4, 32'h8, 2'h0);
		n_fall = 0;
		cyc(300);
		chk(n_fall, 0);
		// upper control bits set too: none of them may stop the watchdog
		wr(4'h8, 32'hfffffff9);
		cyc(1);
		chk(core_halt, 1);
		ticks(3);
		wt(0, 1'b1);
		chk(n_fall != 0, 1);
		chk(core_halt, 0);
		rd(4'h4, 32'h10, 2'h0);
		boot(16'h8011, 5'b10101);
		chk(n + 3 >= PW && n + 3 <= PW + 5, 1);
		rd(4'h0, 32'hffb1, 2'h0);
		wr(4'h8, 32'h1);
		cyc(1);
		irq_wake <= 1'b1;
		wt(1, 1'b0);
		irq_wake <= 1'b0;
		chk(n <= 3, 1);
		n_fall = 0;
		ticks(6);
		cyc(8);
		chk(n_fall, 0);
		rd(4'h4, 32'h4, 2'h0);
		close_out;
	end
	initial begin
		cyc(20000);
		n_mismatch++;
		close_out;
	end
endmodule
